// ### logic/tewr_fifo.sv
// pixel fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module tewr_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two of at least two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = cnt_q < (AW + 1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign empty_o = cnt_q == '0;
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // tewr_fifo
`default_nettype wire

// ### logic/tewr_fifo_fix.sv
// unused
`timescale 1ns/1ns

// ### logic/tewr_pkg.sv
// constants and types shared by the trigger, exposure and window readout block
// ****************************************************************************
// Summary of operation
// - Positive polarity starts exposure on rising edge, negative on falling edge.
// - Triggered shutter offers fixed-duration and pulse-width sub-modes.
// - Fixed mode times exposure from programmed shutter length, ignoring pulse width.
// - Pulse-width mode exposes for the active pulse plus two clocks.
// - No new exposure until the previous image output has completed.
// - Commands are not serviced while an exposure is in progress.
// - One to twenty-eight rectangular windows, overlapping allowed.
// - Window horizontal start is a multiple of four; vertical start any row.
// - Window width multiple of four, at least sixteen; height at least two.
// - Windows extending past the pixel array are refused.
// - Window readout never combines with binning or subsampling.
// - Whole window set saves to and recalls from eight banks.
// - Output is line by line; a line carries pixels of every window crossing it.
// - Wide dynamic range exposes each frame in at most two slopes.
// - Second slope lasts a quarter, sixteenth or sixty-fourth of the first.
// - Second slope is never shorter than fifty microseconds.
// - Dual slope is off with shutter off or in pulse-width mode.
// - Binning of two-by-two pixels never combines with window or subsampling.
// ****************************************************************************
package tewr_pkg;
  localparam int unsigned DIM_W = 13;
  localparam logic [DIM_W-1:0] ARRAY_W = 13'h1000;
  localparam logic [DIM_W-1:0] ARRAY_H = 13'h0c00;
  localparam int unsigned MAX_WIN = 28;
  localparam int unsigned WIN_IDX_W = 5;
  localparam int unsigned NUM_BANKS = 8;
  localparam int unsigned BANK_W = 3;
  localparam logic [DIM_W-1:0] H_ALIGN_MASK = 13'h0003;
  localparam logic [DIM_W-1:0] MIN_WIN_W = 13'h0010;
  localparam logic [DIM_W-1:0] MIN_WIN_H = 13'h0002;
  localparam int unsigned SHUT_W = 32;
  localparam logic [SHUT_W-1:0] PULSE_EXTRA_CYC = 32'h0000_0002;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SLOPE2_MIN_NS = 50000;
  localparam int unsigned SLOPE2_MIN_CYC = (SLOPE2_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXPOSE = 3'b001,
    ST_TAIL = 3'b010,
    ST_SLOPE_RST = 3'b011,
    ST_SLOPE2 = 3'b100,
    ST_READ = 3'b101,
    ST_DRAIN = 3'b110
  } tewr_state_t;

  typedef enum logic [1:0] {
    RD_ALL = 2'b00,
    RD_BIN = 2'b01,
    RD_SUB = 2'b10,
    RD_WIN = 2'b11
  } tewr_rdmode_t;

  typedef enum logic [1:0] {
    SLOPE_OFF = 2'b00,
    SLOPE_QUARTER = 2'b01,
    SLOPE_SIXTEENTH = 2'b10,
    SLOPE_SIXTYFOURTH = 2'b11
  } tewr_slope_t;
endpackage

// ### logic/tewr_top.sv
// trigger, exposure timing and region window readout control
`timescale 1ns/1ns
`default_nettype none
module tewr_top #(
  parameter int unsigned PIX_W = tewr_pkg::PIX_W,
  parameter int unsigned FIFO_DEPTH = tewr_pkg::FIFO_DEPTH,
  parameter int unsigned SLOPE2_MIN_CYC = tewr_pkg::SLOPE2_MIN_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // trigger inputs
  input wire logic cc1_trig_i,
  input wire logic power_connector_trigger_input_i,
  // shutter configuration
  input wire logic trig_enable_i,
  input wire logic trig_pol_pos_i,
  input wire logic trig_pulse_mode_i,
  input wire logic shutter_on_i,
  input wire logic [tewr_pkg::SHUT_W-1:0] shutter_cycles_i,
  input wire logic [1:0] slope_mode_i,
  // readout configuration
  input wire logic [1:0] readout_mode_i,
  input wire logic [1:0] sub_sel_i,
  // command path
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  // region window configuration
  input wire logic win_wr_i,
  input wire logic [tewr_pkg::WIN_IDX_W-1:0] win_idx_i,
  input wire logic [tewr_pkg::DIM_W-1:0] win_hstart_i,
  input wire logic [tewr_pkg::DIM_W-1:0] win_vstart_i,
  input wire logic [tewr_pkg::DIM_W-1:0] win_width_i,
  input wire logic [tewr_pkg::DIM_W-1:0] win_height_i,
  input wire logic win_en_i,
  output logic win_rej_o,
  input wire logic bank_save_i,
  input wire logic bank_recall_i,
  input wire logic [tewr_pkg::BANK_W-1:0] bank_num_i,
  // sensor side
  output logic exposing_o,
  output logic slope_reset_o,
  output logic reading_o,
  output logic bin_o,
  output logic [tewr_pkg::DIM_W-1:0] row_o,
  output logic [tewr_pkg::DIM_W-1:0] col_o,
  input wire logic [PIX_W-1:0] pix_data_i,
  // pixel stream out
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [PIX_W-1:0] out_data_o,
  output logic out_sof_o,
  output logic out_sol_o
);
  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (PIX_W < 1 || PIX_W > 16) begin : g_chk_pix
    $error("pixel width must lie between 1 and 16");
  end
  if (SLOPE2_MIN_CYC < 1) begin : g_chk_slope
    $error("second slope floor must be at least one cycle");
  end

  localparam int unsigned D = tewr_pkg::DIM_W;
  localparam int unsigned SW = tewr_pkg::SHUT_W;
  localparam logic [SW-1:0] SLOPE2_MIN = SW'(SLOPE2_MIN_CYC);

  tewr_pkg::tewr_state_t state_q;
  tewr_pkg::tewr_rdmode_t mode_q;
  logic lvl;
  logic lvl_q;
  logic edge_seen;
  logic start;
  logic [SW-1:0] cnt_q;
  logic [SW-1:0] len_q;
  logic [SW-1:0] slope2_len_q;
  logic pulse_q;
  logic slope_q;
  logic [1:0] sub_q;
  logic [D-1:0] row_q;
  logic [D-1:0] col_q;
  logic sof_q;
  logic sol_q;
  logic win_hit;
  logic win_row_hit;
  logic sel;
  logic fifo_ready;
  logic fifo_empty;
  logic push;
  logic advance;
  logic row_end;
  logic row_skip;
  logic [D:0] col_sum;
  logic [D:0] row_sum;
  logic [D-1:0] step;
  logic cfg_ok;
  logic [PIX_W+1:0] fifo_out;

  function automatic logic [D:0] add_step(input logic [D-1:0] a, input logic [D-1:0] s);
    return {1'b0, a} + {1'b0, s};
  endfunction

  function automatic logic [SW-1:0] slope2_of(input logic [SW-1:0] first,
                                              input logic [1:0] m,
                                              input logic [SW-1:0] floor_v);
    logic [SW-1:0] v;
    v = '0;
    unique case (m)
      tewr_pkg::SLOPE_QUARTER: v = first >> 2;
      tewr_pkg::SLOPE_SIXTEENTH: v = first >> 4;
      tewr_pkg::SLOPE_SIXTYFOURTH: v = first >> 6;
      tewr_pkg::SLOPE_OFF: v = first;
    endcase
    return (v < floor_v) ? floor_v : v;
  endfunction

  // ****************************************************************
  // trigger detection
  // ****************************************************************
  // both inputs are ORed: the far side holds the idle one low
  assign lvl = (cc1_trig_i | power_connector_trigger_input_i) ^ ~trig_pol_pos_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl;
    end
  end

  assign edge_seen = lvl && !lvl_q;
  // edges outside idle are simply not looked at, so nothing queues
  assign start = (state_q == tewr_pkg::ST_IDLE)
      && (trig_enable_i ? edge_seen : 1'b1);

  // ****************************************************************
  // command gating
  // ****************************************************************
  assign exposing_o = (state_q == tewr_pkg::ST_EXPOSE) || (state_q == tewr_pkg::ST_TAIL)
      || (state_q == tewr_pkg::ST_SLOPE_RST) || (state_q == tewr_pkg::ST_SLOPE2);
  assign cmd_ready_o = !exposing_o;
  // window table only changes between frames, so a frame never sees a half update
  assign cfg_ok = state_q == tewr_pkg::ST_IDLE;
  assign reading_o = (state_q == tewr_pkg::ST_READ) || (state_q == tewr_pkg::ST_DRAIN);
  assign slope_reset_o = state_q == tewr_pkg::ST_SLOPE_RST;
  assign bin_o = reading_o && (mode_q == tewr_pkg::RD_BIN);

  // ****************************************************************
  // frame setup latched at exposure start
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= 32'h0000_0001;
      slope2_len_q <= 32'h0000_0001;
      pulse_q <= 1'b0;
      slope_q <= 1'b0;
      mode_q <= tewr_pkg::RD_ALL;
      sub_q <= 2'h1;
    end else if (start) begin
      // shutter off integrates over readout, so only a token exposure here
      len_q <= (!shutter_on_i || shutter_cycles_i == '0) ? 32'h0000_0001
          : shutter_cycles_i;
      slope2_len_q <= slope2_of(shutter_cycles_i, slope_mode_i, SLOPE2_MIN);
      pulse_q <= trig_enable_i && trig_pulse_mode_i;
      slope_q <= (slope_mode_i != tewr_pkg::SLOPE_OFF) && shutter_on_i
          && !(trig_enable_i && trig_pulse_mode_i);
      // one encoded mode field keeps the readout modes mutually exclusive
      mode_q <= tewr_pkg::tewr_rdmode_t'(readout_mode_i);
      sub_q <= (sub_sel_i == 2'h0) ? 2'h1 : sub_sel_i;
    end
  end

  // ****************************************************************
  // exposure and readout sequencing
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= tewr_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        tewr_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (start) state_q <= tewr_pkg::ST_EXPOSE;
        end
        tewr_pkg::ST_EXPOSE: begin
          cnt_q <= cnt_q + 1'b1;
          if (pulse_q) begin
            if (!lvl) begin
              state_q <= tewr_pkg::ST_TAIL;
              cnt_q <= '0;
            end
          end else if (cnt_q >= len_q - 1'b1) begin
            cnt_q <= '0;
            state_q <= slope_q ? tewr_pkg::ST_SLOPE_RST : tewr_pkg::ST_READ;
          end
        end
        tewr_pkg::ST_TAIL: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == tewr_pkg::PULSE_EXTRA_CYC - 1'b1) begin
            state_q <= tewr_pkg::ST_READ;
          end
        end
        tewr_pkg::ST_SLOPE_RST: begin
          cnt_q <= '0;
          state_q <= tewr_pkg::ST_SLOPE2;
        end
        tewr_pkg::ST_SLOPE2: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= slope2_len_q - 1'b1) begin
            state_q <= tewr_pkg::ST_READ;
          end
        end
        tewr_pkg::ST_READ: begin
          cnt_q <= '0;
          if (advance && row_end && (row_sum >= {1'b0, tewr_pkg::ARRAY_H})) begin
            state_q <= tewr_pkg::ST_DRAIN;
          end
        end
        tewr_pkg::ST_DRAIN: begin
          // idle only once the last pixel has left the fifo
          if (fifo_empty) state_q <= tewr_pkg::ST_IDLE;
        end
        default: state_q <= tewr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // pixel scan
  // ****************************************************************
  always_comb begin
    step = 13'h0001;
    unique case (mode_q)
      tewr_pkg::RD_BIN: step = 13'h0002;
      tewr_pkg::RD_SUB: step = D'(13'h0001 << (sub_q));
      tewr_pkg::RD_ALL, tewr_pkg::RD_WIN: step = 13'h0001;
    endcase
  end

  assign sel = (mode_q == tewr_pkg::RD_WIN) ? win_hit : 1'b1;
  // rows that no window crosses are skipped in one cycle
  assign row_skip = (mode_q == tewr_pkg::RD_WIN) && !win_row_hit;
  assign col_sum = add_step(col_q, step);
  assign row_sum = add_step(row_q, step);
  assign row_end = row_skip || (col_sum >= {1'b0, tewr_pkg::ARRAY_W});
  assign push = (state_q == tewr_pkg::ST_READ) && sel && !row_skip && fifo_ready;
  assign advance = (state_q == tewr_pkg::ST_READ) && (row_skip || !sel || fifo_ready);
  assign row_o = row_q;
  assign col_o = col_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_q <= '0;
      col_q <= '0;
    end else if (state_q != tewr_pkg::ST_READ) begin
      row_q <= '0;
      col_q <= '0;
    end else if (advance) begin
      if (row_end) begin
        col_q <= '0;
        row_q <= row_sum[D-1:0];
      end else begin
        col_q <= col_sum[D-1:0];
      end
    end
  end

  // first pixel of frame and of each line are marked so lines can be rebuilt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sof_q <= 1'b1;
      sol_q <= 1'b1;
    end else if (state_q != tewr_pkg::ST_READ) begin
      sof_q <= 1'b1;
      sol_q <= 1'b1;
    end else begin
      if (push) sof_q <= 1'b0;
      if (advance && row_end) begin
        sol_q <= 1'b1;
      end else if (push) begin
        sol_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // window table and output fifo
  // ****************************************************************
  tewr_win_table u_win (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(win_wr_i && cfg_ok),
    .idx_i(win_idx_i),
    .hstart_i(win_hstart_i),
    .vstart_i(win_vstart_i),
    .width_i(win_width_i),
    .height_i(win_height_i),
    .en_i(win_en_i),
    .rej_o(win_rej_o),
    .save_i(bank_save_i && cfg_ok && !cmd_valid_i),
    .recall_i(bank_recall_i && cfg_ok && !cmd_valid_i),
    .bank_i(bank_num_i),
    .row_i(row_q),
    .col_i(col_q),
    .hit_o(win_hit),
    .row_hit_o(win_row_hit)
  );

  tewr_fifo #(
    .WIDTH(PIX_W + 2),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i({sof_q, sol_q, pix_data_i}),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(fifo_out),
    .empty_o(fifo_empty)
  );

  assign out_data_o = fifo_out[PIX_W-1:0];
  assign out_sol_o = fifo_out[PIX_W];
  assign out_sof_o = fifo_out[PIX_W+1];
endmodule // tewr_top
`default_nettype wire

// ### logic/tewr_win_table.sv
// region window table with eight save/recall banks and coverage decode
`timescale 1ns/1ns
`default_nettype none
module tewr_win_table (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // window write port
  input wire logic wr_i,
  input wire logic [tewr_pkg::WIN_IDX_W-1:0] idx_i,
  input wire logic [tewr_pkg::DIM_W-1:0] hstart_i,
  input wire logic [tewr_pkg::DIM_W-1:0] vstart_i,
  input wire logic [tewr_pkg::DIM_W-1:0] width_i,
  input wire logic [tewr_pkg::DIM_W-1:0] height_i,
  input wire logic en_i,
  output logic rej_o,
  // bank port
  input wire logic save_i,
  input wire logic recall_i,
  input wire logic [tewr_pkg::BANK_W-1:0] bank_i,
  // coverage lookup
  input wire logic [tewr_pkg::DIM_W-1:0] row_i,
  input wire logic [tewr_pkg::DIM_W-1:0] col_i,
  output logic hit_o,
  output logic row_hit_o
);
  localparam int unsigned N = tewr_pkg::MAX_WIN;
  localparam int unsigned D = tewr_pkg::DIM_W;
  logic [D-1:0] hs_q [N], vs_q [N], w_q [N], h_q [N];
  logic en_q [N];
  logic [D-1:0] bhs_q [tewr_pkg::NUM_BANKS][N], bvs_q [tewr_pkg::NUM_BANKS][N];
  logic [D-1:0] bw_q [tewr_pkg::NUM_BANKS][N], bh_q [tewr_pkg::NUM_BANKS][N];
  logic ben_q [tewr_pkg::NUM_BANKS][N];
  logic legal;

  function automatic logic in_span(input logic [D-1:0] p, input logic [D-1:0] s,
                                   input logic [D-1:0] len);
    return ({1'b0, p} >= {1'b0, s}) && ({1'b0, p} < ({1'b0, s} + {1'b0, len}));
  endfunction

  function automatic logic fits(input logic [D-1:0] s, input logic [D-1:0] len,
                                input logic [D-1:0] lim);
    return ({1'b0, s} + {1'b0, len}) <= {1'b0, lim};
  endfunction

  assign legal = (idx_i < tewr_pkg::WIN_IDX_W'(N))
      && ((hstart_i & tewr_pkg::H_ALIGN_MASK) == '0)
      && ((width_i & tewr_pkg::H_ALIGN_MASK) == '0) && (width_i >= tewr_pkg::MIN_WIN_W)
      && (height_i >= tewr_pkg::MIN_WIN_H)
      && fits(hstart_i, width_i, tewr_pkg::ARRAY_W)
      && fits(vstart_i, height_i, tewr_pkg::ARRAY_H);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rej_o <= 1'b0;
      for (int i = 0; i < N; i++) begin
        en_q[i] <= 1'b0;
        hs_q[i] <= '0;
        vs_q[i] <= '0;
        w_q[i] <= '0;
        h_q[i] <= '0;
      end
    end else begin
      rej_o <= wr_i && !legal;
      if (wr_i && legal) begin
        hs_q[idx_i] <= hstart_i;
        vs_q[idx_i] <= vstart_i;
        w_q[idx_i] <= width_i;
        h_q[idx_i] <= height_i;
        en_q[idx_i] <= en_i;
      end else if (recall_i) begin
        for (int i = 0; i < N; i++) begin
          hs_q[i] <= bhs_q[bank_i][i];
          vs_q[i] <= bvs_q[bank_i][i];
          w_q[i] <= bw_q[bank_i][i];
          h_q[i] <= bh_q[bank_i][i];
          en_q[i] <= ben_q[bank_i][i];
        end
      end
    end
  end

  // banks keep their contents across reset, as nonvolatile storage would
  always_ff @(posedge clk_i) begin
    if (save_i) begin
      for (int i = 0; i < N; i++) begin
        bhs_q[bank_i][i] <= hs_q[i];
        bvs_q[bank_i][i] <= vs_q[i];
        bw_q[bank_i][i] <= w_q[i];
        bh_q[bank_i][i] <= h_q[i];
        ben_q[bank_i][i] <= en_q[i];
      end
    end
  end

  // overlapping windows simply OR together, so shared pixels go out once
  always_comb begin
    hit_o = 1'b0;
    row_hit_o = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (en_q[i] && in_span(row_i, vs_q[i], h_q[i])) begin
        row_hit_o = 1'b1;
        if (in_span(col_i, hs_q[i], w_q[i])) hit_o = 1'b1;
      end
    end
  end
endmodule // tewr_win_table
`default_nettype wire

// ### tb/tewr_grabber_model.sv
// trigger source, pixel array and frame grabber facing the block
`timescale 1ns/1ns
`default_nettype none
module tewr_grabber_model (
  // clock and trigger request
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic pol_pos_i,
  input wire logic use_pwr_i,
  // trigger lines
  output logic cc1_o,
  output logic pwr_o,
  // pixel array and stream sink
  input wire logic [12:0] row_i,
  input wire logic [12:0] col_i,
  output logic [11:0] pix_o,
  output logic ready_o
);
  integer seed = 32'h8b0d;
  // idle level is the inactive polarity; the unused line stays low
  assign cc1_o = !use_pwr_i && (fire_i == pol_pos_i);
  assign pwr_o = use_pwr_i && (fire_i == pol_pos_i);
  assign pix_o = row_i[11:0] * 12'h7 + col_i[11:0];
  // random stalls let the fifo fill up
  always @(negedge clk_i) ready_o <= 1'($random(seed));
endmodule // tewr_grabber_model
`default_nettype wire

// ### tb/tewr_properties.sv
// concurrent checks on the ports of the trigger, exposure and window readout top
`timescale 1ns/1ns
`default_nettype none
module tewr_properties #(
  parameter int unsigned SLOPE2_MIN_CYC = tewr_pkg::SLOPE2_MIN_CYC
) (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cc1_trig_i,
  input wire logic power_connector_trigger_input_i,
  input wire logic trig_pol_pos_i,
  input wire logic trig_pulse_mode_i,
  input wire logic shutter_on_i,
  input wire logic [31:0] shutter_cycles_i,
  input wire logic [1:0] slope_mode_i,
  input wire logic win_wr_i,
  input wire logic [4:0] win_idx_i,
  input wire logic [12:0] win_hstart_i,
  input wire logic [12:0] win_vstart_i,
  input wire logic [12:0] win_width_i,
  input wire logic [12:0] win_height_i,
  input wire logic win_rej_o,
  input wire logic cmd_ready_o,
  input wire logic exposing_o,
  input wire logic slope_reset_o,
  input wire logic reading_o
);
  // ****
  // helpers
  // ****
  logic [31:0] cnt_q;
  logic [31:0] s2;
  logic [31:0] want;
  logic act;
  logic idle;
  logic bad;
  assign act = (cc1_trig_i | power_connector_trigger_input_i) == trig_pol_pos_i;
  assign idle = !exposing_o && !reading_o;
  assign s2 = shutter_cycles_i >> {slope_mode_i, 1'b0};
  // floor keeps a short first slope from giving a uselessly short second one
  assign want = !shutter_on_i ? 32'h1 : shutter_cycles_i + (slope_mode_i == 2'h0 ? 32'h0 :
    32'h1 + (s2 < SLOPE2_MIN_CYC ? SLOPE2_MIN_CYC : s2));
  assign bad = win_idx_i > 5'h1b || win_hstart_i[1:0] != 2'h0 || win_width_i[1:0] != 2'h0
    || win_width_i < 13'h10 || win_height_i < 13'h2
    || 14'(win_hstart_i) + 14'(win_width_i) > 14'h1000
    || 14'(win_vstart_i) + 14'(win_height_i) > 14'h0c00;
  always_ff @(posedge clk_i) begin
    cnt_q <= (rst_i || !exposing_o) ? 32'h0 : cnt_q + 32'h1;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_cmd_gate: assert property (cmd_ready_o == !exposing_o)
    else $error("command path open during exposure");
  a_one_phase: assert property (!(exposing_o && reading_o))
    else $error("exposure overlaps readout");
  a_edge_start: assert property (idle && $rose(act) |=> exposing_o)
    else $error("active trigger edge did not start exposure");
  a_read_blocks: assert property (reading_o |=> !exposing_o)
    else $error("exposure started straight from readout");
  a_fixed_len: assert property ($fell(exposing_o) && !trig_pulse_mode_i
    |-> cnt_q == want)
    else $error("fixed exposure length wrong");
  a_pulse_tail: assert property (trig_pulse_mode_i && exposing_o && $fell(act)
    |-> exposing_o [*3] ##1 !exposing_o)
    else $error("pulse exposure tail not two cycles");
  a_slope_gate: assert property (slope_reset_o |-> shutter_on_i && !trig_pulse_mode_i
    && slope_mode_i != 2'h0)
    else $error("slope reset where dual slope is barred");
  a_reject_bad: assert property (win_wr_i && idle
    |=> win_rej_o == $past(bad))
    else $error("window refusal wrong");
  c_slope: cover property (slope_reset_o);
  c_reject: cover property (win_rej_o);
  c_frame: cover property ($fell(reading_o));
endmodule // tewr_properties
bind tewr_top tewr_properties #(.SLOPE2_MIN_CYC(SLOPE2_MIN_CYC)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .cc1_trig_i(cc1_trig_i),
  .power_connector_trigger_input_i(power_connector_trigger_input_i),
  .trig_pol_pos_i(trig_pol_pos_i), .trig_pulse_mode_i(trig_pulse_mode_i),
  .shutter_on_i(shutter_on_i), .shutter_cycles_i(shutter_cycles_i), .slope_mode_i(slope_mode_i),
  .win_wr_i(win_wr_i), .win_idx_i(win_idx_i), .win_hstart_i(win_hstart_i),
  .win_vstart_i(win_vstart_i), .win_width_i(win_width_i), .win_height_i(win_height_i),
  .win_rej_o(win_rej_o), .cmd_ready_o(cmd_ready_o), .exposing_o(exposing_o),
  .slope_reset_o(slope_reset_o), .reading_o(reading_o));
`default_nettype wire

// ### tb/tewr_top_bench.sv
// self-checking bench for the trigger, exposure and window readout top
`timescale 1ns/1ns
`default_nettype none
module tewr_top_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fire = 1'b0;
  logic up = 1'b0;
  logic pol = 1'b1;
  logic cc1, pwr, rdy, rej, expo, rd, vld, sof, sol, wr, en, sv, rc, pm, son, bno;
  logic [1:0] sl;
  logic [4:0] idx;
  logic [12:0] hs, vs, wd, ht, row, col;
  logic [11:0] pix, dat;
  logic [31:0] sh;
  logic [2:0] bk;
  logic [13:0] q[$];
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int exp_n = 0;
  int wh[28], wv[28], ww[28], wt[28];
  bit we[28];
  always #4 clk_i = ~clk_i;
  tewr_grabber_model i_tewr_grabber_model (.clk_i(clk_i), .fire_i(fire), .pol_pos_i(pol),
    .use_pwr_i(up), .cc1_o(cc1), .pwr_o(pwr), .row_i(row), .col_i(col), .pix_o(pix),
    .ready_o(rdy));
  tewr_top #(.SLOPE2_MIN_CYC(4)) i_tewr_top (.clk_i(clk_i), .rst_i(rst_i), .cc1_trig_i(cc1),
    .power_connector_trigger_input_i(pwr), .trig_enable_i(1'b1), .trig_pol_pos_i(pol),
    .trig_pulse_mode_i(pm), .shutter_on_i(son), .shutter_cycles_i(sh), .slope_mode_i(sl),
    .readout_mode_i(2'h3), .sub_sel_i(2'h0), .cmd_valid_i(1'b0), .cmd_ready_o(),
    .win_wr_i(wr), .win_idx_i(idx), .win_hstart_i(hs), .win_vstart_i(vs), .win_width_i(wd),
    .win_height_i(ht), .win_en_i(en), .win_rej_o(rej), .bank_save_i(sv), .bank_recall_i(rc),
    .bank_num_i(bk), .exposing_o(expo), .slope_reset_o(), .reading_o(rd), .bin_o(bno),
    .row_o(row), .col_o(col), .pix_data_i(pix), .out_valid_o(vld), .out_ready_i(rdy),
    .out_data_o(dat), .out_sof_o(sof), .out_sol_o(sol));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (expo === 1'b1) exp_n++;
    if (vld === 1'b1 && rdy === 1'b1) chk("pixel", q.pop_front(), {sof, sol, dat});
    if (rd === 1'b1) chk("bin", 0, bno);
    if (cyc == 120000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic win(input int i, h, v, w, t, input bit e);
    bit ok;
    ok = i < 28 && h % 4 == 0 && w % 4 == 0 && w >= 16 && t >= 2 && h + w <= 4096 && v + t <= 3072;
    {wr, idx, hs, vs, wd, ht, en} = {1'b1, 5'(i), 13'(h), 13'(v), 13'(w), 13'(t), e};
    @(negedge clk_i);
    wr = 1'b0;
    chk("reject", !ok, rej);
    @(negedge clk_i);
    if (ok) {wh[i], wv[i], ww[i], wt[i], we[i]} = {h, v, w, t, e};
  endtask
  task automatic frame(input bit p, o, u, input int s, f, input logic [1:0] m, input bit n);
    int e;
    int k;
    int b;
    e = !n ? 1 : p ? f + 2 : s + (m == 0 ? 0 : 1 + ((s >> 2 * m) < 4 ? 4 : s >> 2 * m));
    {pm, pol, up, sh, sl, son} = {p, o, u, 32'(s), m, n};
    for (int r = 0; r < 8; r++) begin
      b = 1;
      for (int c = 0; c < 128; c++) begin
        k = 0;
        for (int i = 0; i < 28; i++)
          k |= we[i] && r >= wv[i] && r < wv[i] + wt[i] && c >= wh[i] && c < wh[i] + ww[i];
        if (k) begin
          q.push_back({q.size() == 0, b[0], 12'(r * 7 + c)});
          b = 0;
        end
      end
    end
    repeat (2) @(negedge clk_i);
    exp_n = 0;
    fire = 1'b1;
    repeat (f) @(negedge clk_i);
    fire = 1'b0;
    // a second pulse lands mid-frame and must be dropped
    for (k = 0; k < 40000 && (expo === 1'b1 || rd === 1'b1 || k < 12); k++) begin
      fire = k >= 8 && k < (p ? 6259 : 10);
      @(negedge clk_i);
    end
    chk("busy", 0, expo | rd);
    chk("exposure", e, exp_n);
    chk("left", 0, q.size());
  endtask
  // ****
  // stimulus
  // ****
  initial begin
    {wr, idx, hs, vs, wd, ht, en, sv, rc, bk, pm, son, sh, sl} = '0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    win(0, 8, 4, 16, 2, 1);
    win(1, 16, 4, 16, 2, 1);
    win(2, 100, 4, 16, 2, 1);
    win(3, 2, 0, 16, 2, 1);
    win(3, 0, 0, 12, 2, 1);
    win(3, 0, 0, 18, 2, 1);
    win(3, 0, 0, 16, 1, 1);
    win(28, 0, 0, 16, 2, 1);
    win(3, 4088, 0, 16, 2, 1);
    win(3, 4080, 3070, 16, 2, 0);
    frame(0, 1, 0, 4, 3, 0, 1);
    frame(1, 0, 1, 4, 6251, 0, 1);
    for (int m = 1; m < 4; m++) frame(0, 1, 0, 64, 3, 2'(m), 1);
    frame(1, 1, 0, 64, 6251, 2'h3, 1);
    frame(0, 1, 0, 64, 3, 2'h1, 0);
    {sv, bk} = 4'hf;
    @(negedge clk_i);
    sv = 1'b0;
    win(2, 100, 4, 16, 2, 0);
    frame(0, 1, 0, 4, 3, 0, 1);
    rc = 1'b1;
    @(negedge clk_i);
    rc = 1'b0;
    we[2] = 1'b1;
    frame(0, 1, 0, 4, 3, 0, 1);
    wrap_up();
  end
endmodule // tewr_top_bench
`default_nettype wire
